// [logic/scs_defs.vh]
// Constants for the conversion sequencer
// Operation
// - The device alternates between acquisition with the sampler tracking the input and conversion that resolves the held sample.
// - The host starts each conversion with a falling convert strobe, and all channels enter conversion on that edge.
// - Conversion steps a 15-bit capacitor DAC through a successive-approximation search from one half down to one 32768th.
// - When the search ends, the 15-bit output code of every channel is assembled and made ready for serial transfer.
// - Twice the reference maps onto 2^15 levels, giving 250 uV steps with a 4.096 V reference.
// - Every result is coded in two's complement, so negative inputs set the sign bit.
// - The device sustains 2 Msps per channel and the result after a strobe belongs to that same sample.
// - The device offers a nap state and a sleep state that save power between bursts.
// - In the pseudo-differential bipolar setup codes are bipolar over half of full scale around the fixed input.
// - In the pseudo-differential unipolar setup codes cover only the non-negative half of full scale.
// - A high convert strobe means acquisition, and driving it low starts conversion and data clock-out.
// - Each result leaves MSB first, on falling serial-clock edges in single rate or on both edges in double rate.
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH
`define SCS_DAC_BITS 15
`define SCS_CODE_BITS 14
`define SCS_CHANNELS 4
`define SCS_FRAME_EDGES 16
`define SCS_LSB_NV 250000
`define SCS_REF_NV 4096000000
`define SCS_CYCLE_NS 500
`define SCS_CLK_NS 10
`define SCS_CYCLE_CLKS (`SCS_CYCLE_NS / `SCS_CLK_NS)
`define SCS_FIFO_DEPTH 16
`endif

// [logic/scs_fifo.v]
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/10ps
module scs_fifo #(
  parameter WIDTH = 60,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                  wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                  rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule // scs_fifo

// [logic/scs_sequencer.v]
// Sampling, successive approximation and serial readout of four channels
`timescale 1ns/10ps
`include "scs_defs.vh"
module scs_sequencer #(
  parameter NCH = 4,
  parameter DEPTH = 16
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Host link pins
  input wire convert_strobe_n_i,
  input wire serial_clock_i,
  input wire edge_rate_select_i,
  output reg echoed_serial_clock_o,
  output reg [NCH-1:0] serial_out_o,
  // Power state request: 00 run, 01 nap, 10 sleep
  input wire [1:0] power_req_i,
  output wire [1:0] power_state_o,
  // Comparator: high when held sample exceeds the DAC trial
  output reg [NCH-1:0] sample_hold_o,
  output reg [`SCS_DAC_BITS-1:0] capacitor_dac_o,
  input wire [NCH-1:0] compare_i,
  // Result stream of all channels, 15 bits each
  output wire result_valid_o,
  input wire result_ready_i,
  output wire [NCH*`SCS_DAC_BITS-1:0] result_data_o,
  output wire result_drop_o
);
  localparam W = `SCS_DAC_BITS;
  localparam ST_ACQ = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_DONE = 2'h2;
  // Offset-binary search result to two's complement
  function [W-1:0] to_twos;
    input [W-1:0] raw;
    begin
      to_twos = {~raw[W-1], raw[W-2:0]};
    end
  endfunction
  reg [1:0] state;
  reg [3:0] bit_idx;
  reg [W-1:0] trial [0:NCH-1];
  reg [W-1:0] shifter [0:NCH-1];
  reg [4:0] edge_cnt;
  reg [2:0] cnv_sync;
  reg [2:0] sck_sync;
  reg [1:0] rate_sync;
  reg [1:0] pwr;
  reg drop;
  wire cnv_fall;
  wire sck_fall;
  wire sck_rise;
  wire shift_now;
  wire fifo_ready;
  wire [NCH*W-1:0] packed_res;
  integer i;
  // Power bits only take effect in acquisition
  assign power_state_o = pwr;
  assign cnv_fall = cnv_sync[2] && !cnv_sync[1];
  assign sck_fall = sck_sync[2] && !sck_sync[1];
  assign sck_rise = !sck_sync[2] && sck_sync[1];
  assign shift_now = sck_fall || (rate_sync[1] && sck_rise);
  assign result_drop_o = drop;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : pack
      // Pushed in the DONE cycle, before trial is rewritten
      assign packed_res[g*W +: W] = to_twos(trial[g]);
    end
  endgenerate
  // Two flip-flops before any logic reads the pins
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnv_sync <= 3'h7;
      sck_sync <= 3'h0;
      rate_sync <= 2'h0;
    end else begin
      cnv_sync <= {cnv_sync[1:0], convert_strobe_n_i};
      sck_sync <= {sck_sync[1:0], serial_clock_i};
      rate_sync <= {rate_sync[0], edge_rate_select_i};
    end
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_ACQ;
      bit_idx <= 4'h0;
      pwr <= 2'h0;
      drop <= 1'b0;
      sample_hold_o <= {NCH{1'b0}};
      capacitor_dac_o <= {W{1'b0}};
      for (i = 0; i < NCH; i = i + 1) begin
        trial[i] <= {W{1'b0}};
      end
    end else begin
      drop <= 1'b0;
      case (state)
        ST_ACQ: begin
          sample_hold_o <= {NCH{1'b0}};
          if (pwr == 2'h0 && cnv_fall) begin
            state <= ST_CONV;
            sample_hold_o <= {NCH{1'b1}};
            bit_idx <= 4'he;
            capacitor_dac_o <= 15'h4000;
            for (i = 0; i < NCH; i = i + 1) begin
              trial[i] <= 15'h4000;
            end
          end else if (cnv_sync[1]) begin
            pwr <= power_req_i;
          end
        end
        ST_CONV: begin
          // Bits resolved one per clock, MSB weight half scale
          for (i = 0; i < NCH; i = i + 1) begin
            trial[i][bit_idx] <= compare_i[i];
            if (bit_idx != 4'h0) begin
              trial[i][bit_idx - 4'h1] <= 1'b1;
            end
          end
          if (bit_idx == 4'h0) begin
            state <= ST_DONE;
          end else begin
            bit_idx <= bit_idx - 4'h1;
            // Keep the bit just decided, then try the next one
            capacitor_dac_o <= (trial[0] & ~(15'h0001 << bit_idx)) |
                               ({14'h0, compare_i[0]} << bit_idx) |
                               (15'h0001 << (bit_idx - 4'h1));
          end
        end
        ST_DONE: begin
          // Same-sample result, no pipeline; offset binary to 2's comp
          for (i = 0; i < NCH; i = i + 1) begin
            trial[i] <= to_twos(trial[i]);
          end
          drop <= !fifo_ready;
          state <= ST_ACQ;
        end
        default: state <= ST_ACQ;
      endcase
    end
  end
  // Output shifters load the finished code, MSB first
  always @(posedge clk_i) begin
    if (rst_i) begin
      edge_cnt <= 5'h0;
      serial_out_o <= {NCH{1'b0}};
      echoed_serial_clock_o <= 1'b0;
      for (i = 0; i < NCH; i = i + 1) begin
        shifter[i] <= {W{1'b0}};
      end
    end else begin
      echoed_serial_clock_o <= sck_sync[1];
      if (state == ST_DONE) begin
        edge_cnt <= 5'h0;
        for (i = 0; i < NCH; i = i + 1) begin
          shifter[i] <= to_twos(trial[i]);
          serial_out_o[i] <= ~trial[i][W-1];
        end
      end else if (shift_now && edge_cnt != `SCS_FRAME_EDGES) begin
        edge_cnt <= edge_cnt + 5'h1;
        for (i = 0; i < NCH; i = i + 1) begin
          shifter[i] <= {shifter[i][W-2:0], 1'b0};
          serial_out_o[i] <= shifter[i][W-2];
        end
      end
    end
  end
  scs_fifo #(
    .WIDTH(NCH*W),
    .DEPTH(DEPTH),
    .AW(4)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(state == ST_DONE),
    .in_ready_o(fifo_ready),
    .in_data_i({packed_res}),
    .out_valid_o(result_valid_o),
    .out_ready_i(result_ready_i),
    .out_data_o(result_data_o)
  );
endmodule // scs_sequencer

// [tb/scs_chk.sv]
// Port assertions for the conversion sequencer
`timescale 1ns/10ps
`include "scs_defs.vh"
module scs_chk #(
  parameter NCH = 4
) (
  // Clock, reset and host pins
  input logic clk_i, rst_i, convert_strobe_n_i, serial_clock_i,
  input logic result_ready_i, echoed_serial_clock_o,
  // Status and result
  input logic result_valid_o, result_drop_o,
  input logic [NCH-1:0] sample_hold_o,
  input logic [1:0] power_state_o,
  input logic [`SCS_DAC_BITS-1:0] capacitor_dac_o,
  input logic [NCH*`SCS_DAC_BITS-1:0] result_data_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_RST_IDLE: assert property ($fell(rst_i) |->
    sample_hold_o == 0 && !result_valid_o) else $error("busy after reset");
  AST_START: assert property ($fell(convert_strobe_n_i) &&
    !sample_hold_o[0] && power_state_o == 2'h0 |-> ##[2:5] sample_hold_o[0])
    else $error("strobe did not start");
  AST_ALL: assert property (sample_hold_o == 0 || &sample_hold_o)
    else $error("channels not together");
  AST_MSB: assert property ($rose(sample_hold_o[0]) |->
    capacitor_dac_o == 15'h4000) else $error("bad first trial");
  AST_LEN: assert property ($rose(sample_hold_o[0]) |->
    ##14 sample_hold_o[0] ##[1:6] !sample_hold_o[0]) else $error("bad length");
  AST_DONE: assert property ($fell(sample_hold_o[0]) |->
    ##[0:3] (result_valid_o || result_drop_o)) else $error("no result");
  AST_HOLDQ: assert property (result_valid_o && !result_ready_i |=>
    result_valid_o && $stable(result_data_o)) else $error("result lost");
  AST_NAP: assert property (power_state_o != 2'h0 |->
    !sample_hold_o[0]) else $error("converting while idle");
  AST_ECHO: assert property ($rose(serial_clock_i) |->
    ##[1:5] echoed_serial_clock_o) else $error("clock not echoed");
endmodule // scs_chk

// [tb/scs_host.sv]
// Behavioural host that strobes a conversion and reads the frame
`timescale 1ns/10ps
module scs_host (
  input wire logic go_i,
  input wire logic ddr_i,
  input wire logic [3:0] sdo_i,
  output logic cnv_n_o,
  output logic sck_o,
  output logic [59:0] cap_o,
  output logic done_o
);
  int e, g;
  initial begin
    cnv_n_o = 1'b1;
    sck_o = 1'b0;
    done_o = 1'b0;
    cap_o = '0;
  end
  // Serial clock stands low outside frames
  always @(posedge go_i) begin
    done_o = 1'b0;
    cnv_n_o = 1'b0;
    #400;
    for (e = 0; e < 16; e++) begin
      if (!ddr_i) sck_o = 1'b1;
      #80;
      for (g = 0; g < 4; g++) if (e < 15) cap_o[g*15+14-e] = sdo_i[g];
      sck_o = ddr_i ? ~sck_o : 1'b0;
      if (!ddr_i) #80;
    end
    #80 cnv_n_o = 1'b1;
    #200 done_o = 1'b1;
  end
endmodule // scs_host

// [tb/tb_top.sv]
// Self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module tb_top;
  logic clk_i = 0, rst_i = 1, edge_rate_select_i = 0, result_ready_i = 0;
  logic go = 0, done, convert_strobe_n_i, serial_clock_i;
  logic echoed_serial_clock_o, result_valid_o, result_drop_o;
  logic [1:0] power_req_i = 0, power_state_o;
  logic [3:0] compare_i = 0, serial_out_o, sample_hold_o;
  logic [14:0] capacitor_dac_o, v [4];
  logic [59:0] result_data_o, cap, ex, d;
  int n_errors = 0, num_checks = 0, i, drops = 0;
  always #5 clk_i = ~clk_i;
  // Ideal comparators: each channel's own trial keeps its decided bits,
  // so the answer is the input's bit at the trial position
  wire [14:0] low_bit = capacitor_dac_o & (~capacitor_dac_o + 15'h1);
  always @(negedge clk_i) compare_i <= {|(v[3] & low_bit),
    |(v[2] & low_bit), |(v[1] & low_bit), |(v[0] & low_bit)};
  always @(posedge clk_i) if (result_drop_o === 1'b1) drops++;
  scs_sequencer i_dut (.clk_i, .rst_i, .convert_strobe_n_i, .serial_clock_i,
    .edge_rate_select_i, .echoed_serial_clock_o, .serial_out_o, .power_req_i,
    .power_state_o, .sample_hold_o, .capacitor_dac_o, .compare_i,
    .result_valid_o, .result_ready_i, .result_data_o, .result_drop_o);
  scs_host i_host (.go_i(go), .ddr_i(edge_rate_select_i),
    .sdo_i(serial_out_o), .cnv_n_o(convert_strobe_n_i),
    .sck_o(serial_clock_i), .cap_o(cap), .done_o(done));
  task automatic check(input logic [59:0] seen, input logic [59:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // 0 host done, 1 result valid, 2 power state reached
  task automatic await(input int w);
    int n;
    for (n = 0; n < 2000 && (w == 0 ? done : w == 1 ? result_valid_o :
      power_state_o == power_req_i) !== 1'b1; n++) @(negedge clk_i);
    if (n == 2000) begin n_errors++; end_of_test; end
  endtask
  task automatic convert(input logic [59:0] vals);
    for (i = 0; i < 4; i++) v[i] = vals[i*15+:15];
    go = 1;
    @(negedge clk_i);
    await(0);
    go = 0;
    @(negedge clk_i);
  endtask
  task automatic pop(output logic [59:0] q);
    await(1);
    q = result_data_o;
    result_ready_i = 1;
    @(negedge clk_i);
    result_ready_i = 0;
  endtask
  task automatic conv_chk(input logic [59:0] vals);
    convert(vals);
    for (i = 0; i < 4; i++) ex[i*15+:15] = v[i] ^ 15'h4000;
    check(cap, ex);
    pop(d);
    check(d, ex);
  endtask
  task automatic scn_sdr;
    edge_rate_select_i = 0;
    conv_chk({15'h2abc, 15'h4000, 15'h7fff, 15'h0000});
  endtask
  task automatic scn_ddr;
    edge_rate_select_i = 1;
    conv_chk({15'h3fff, 15'h7ffe, 15'h0001, 15'h5555});
    edge_rate_select_i = 0;
  endtask
  task automatic scn_power;
    int k;
    for (k = 1; k >= 0; k--) begin
      power_req_i = k ? 2'h1 : 2'h2;
      await(2);
      check(power_state_o, power_req_i);
      convert(60'h0);
      check(result_valid_o, 1'b0);
    end
    power_req_i = 2'h0;
    await(2);
  endtask
  // Far side stalls while the buffer fills past its depth
  task automatic scn_fifo;
    int n;
    for (n = 0; n < 17; n++) convert({4{n[14:0]}});
    check(drops, 1);
    for (n = 0; n < 16; n++) begin
      pop(d);
      check(d, {4{n[14:0] ^ 15'h4000}});
    end
    check(result_valid_o, 1'b0);
  endtask
  initial begin
    for (i = 0; i < 4; i++) v[i] = 0;
    repeat (16) @(negedge clk_i);
    rst_i = 0;
    @(negedge clk_i);
    check(serial_out_o, 4'h0);
    scn_sdr;
    scn_ddr;
    scn_power;
    scn_fifo;
    end_of_test;
  end
endmodule // tb_top
bind scs_sequencer scs_chk #(.NCH(NCH)) i_chk (.clk_i, .rst_i,
  .convert_strobe_n_i, .serial_clock_i, .result_ready_i,
  .echoed_serial_clock_o, .result_valid_o, .result_drop_o, .sample_hold_o,
  .power_state_o, .capacitor_dac_o, .result_data_o);
